// File: omc_pkg.sv
// What this block does
// R1 - transmit-off high turns laser off
// R2 - floating transmit-off also disables transmitter
// R3 - pin OR software bit disables transmitter
// R4 - control byte bit 7 shows transmit-off
// R5 - transmit-off toggle resets a tripped transmitter
// R6 - laser fault or low supply disables laser
// R7 - fault pin open collector, high means fault
// R8 - laser fault latches the fault output
// R9 - latch clears only by toggle or power
// R10 - low supply fault follows, never latched
// R11 - control byte bit 2 shows fault
// R12 - eye-safety trip counts as laser fault
// R13 - lost-signal output high on weak input
// R14 - control byte bit 1 shows lost signal
// R15 - identification page answers at address A0h
// R16 - diagnostic page answers at address A2h
// R17 - five calibrated live values in diagnostics
// R18 - software disable bit reads zero after reset
package omc_pkg;
   // two-wire device addresses, seven bits without the direction bit
   localparam logic [6:0] OMC_ID_DEV       = 7'h50;
   localparam logic [6:0] OMC_DIAG_DEV     = 7'h51;
   localparam int         OMC_PAGE_BIT     = 1;
   localparam int         OMC_DIR_BIT      = 0;
   localparam logic [3:0] OMC_BYTE_BITS    = 4'h8;
   localparam int         OMC_MEM_DEPTH    = 256;

   // control and status byte on the diagnostic page
   localparam logic [7:0] OMC_CTRL_OFFSET  = 8'h6e;
   localparam int         OMC_TXOFF_BIT    = 7;
   localparam int         OMC_SOFT_BIT     = 6;
   localparam int         OMC_FAULT_BIT    = 2;
   localparam int         OMC_LOS_BIT      = 1;
   localparam logic       OMC_SOFT_RESET   = 1'b0;

   // live values: temperature, supply, bias, transmit power, receive power
   localparam int         OMC_DIAG_CHANNELS = 5;
   localparam int         OMC_DIAG_WIDTH    = 16;
   localparam logic [7:0] OMC_DIAG_BASE     = 8'h60;
   localparam logic [7:0] OMC_DIAG_END      = 8'h6a;
endpackage

// File: omc_tx_guard.sv
`timescale 1ns/1ps
module omc_tx_guard (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // disable requests
   input  wire logic txOffPin,
   input  wire logic txOffFloat,
   input  wire logic softDisable,
   // fault detectors
   input  wire logic laserFaultDet,
   input  wire logic lowSupply,
   // results
   output logic      laserEnable,
   output logic      txFaultOe,
   output logic      txFaultOut,
   output logic      txOffStat,
   output logic      txFaultStat
);
   logic txOffPrev;
   logic faultLatched;
   logic txOffReq;
   logic clearEv;
   logic next_latched;
   logic faultNow;

   // an open pin reads as a request to turn off
   assign txOffReq     = txOffPin | txOffFloat;                  // [R1] [R2]
   // falling edge ends a toggle; a fresh trip in that cycle still wins
   assign clearEv      = txOffPrev & ~txOffReq;                  // [R9]
   assign next_latched = laserFaultDet | (faultLatched & ~clearEv); // [R8] [R12] [R5]
   // low supply joins the fault output without touching the latch
   assign faultNow     = next_latched | lowSupply;               // [R10] [R6]

   // latch and edge history
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         txOffPrev    <= 1'b1;
         faultLatched <= 1'b0;
      end else begin
         txOffPrev    <= txOffReq;
         faultLatched <= next_latched;
      end
   end

   // registered pins; the fault pin pulls low only while healthy
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         laserEnable <= 1'b0;
         txFaultOe   <= 1'b0;
         txFaultOut  <= 1'b0;
         txOffStat   <= 1'b1;
         txFaultStat <= 1'b0;
      end else begin
         laserEnable <= ~(txOffReq | softDisable | faultNow);    // [R3] [R6]
         txFaultOe   <= ~faultNow;                               // [R7]
         txFaultOut  <= 1'b0;
         txOffStat   <= txOffReq;
         txFaultStat <= faultNow;
      end
   end

   laser_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
      txOffPin |=> !laserEnable) else $error("laser on while pin high");
   float_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2]
      txOffFloat |=> !laserEnable) else $error("laser on while pin open");
   soft_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R3]
      softDisable |=> !laserEnable) else $error("laser on while soft disabled");
   // the second cycle may already show a toggle that cleared the latch
   fault_latch_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R8]
      laserFaultDet |=> (!txFaultOe && !laserEnable)
      ##1 ($past(clearEv & ~laserFaultDet) || (!txFaultOe && !laserEnable)))
      else $error("fault not latched");
   fault_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R9]
      (faultLatched && !clearEv) |=> faultLatched) else $error("fault lost");
   fault_reset_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
      (faultLatched && clearEv && !laserFaultDet) |=> !faultLatched)
      else $error("toggle did not reset");
   low_supply_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R10]
      (!lowSupply && !laserFaultDet && !faultLatched) |=> txFaultOe)
      else $error("low supply fault held");
endmodule // omc_tx_guard

// File: omc_rx_diag.sv
`timescale 1ns/1ps
module omc_rx_diag #(
   parameter int CHANNELS = omc_pkg::OMC_DIAG_CHANNELS,
   parameter int WIDTH    = omc_pkg::OMC_DIAG_WIDTH
) (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   // receiver and monitor inputs
   input  wire logic                      rxPowerLow,
   input  wire logic [CHANNELS*WIDTH-1:0] liveVal,
   input  wire logic                      freeze,
   // results
   output logic                           receiveSignalLost,
   output logic [CHANNELS*WIDTH-1:0]      heldVal
);
   // weak input raises lost-signal
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         receiveSignalLost <= 1'b1;
      end else begin
         receiveSignalLost <= rxPowerLow;                        // [R13]
      end
   end

   // hold values while a read runs so both bytes of a word match
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               heldVal[ch*WIDTH +: WIDTH] <= '0;
            end else if (!freeze) begin
               heldVal[ch*WIDTH +: WIDTH] <= liveVal[ch*WIDTH +: WIDTH]; // [R17]
            end
         end
      end
   endgenerate

   los_follow_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R13]
      rxPowerLow |=> receiveSignalLost) else $error("lost-signal not raised");
endmodule // omc_rx_diag

// File: omc_control_status.sv
`timescale 1ns/1ps
module omc_control_status (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // transmitter control pins
   input  wire logic        txOffPin,
   input  wire logic        txOffFloat,
   input  wire logic        laserFaultDet,
   input  wire logic        lowSupply,
   output logic             laserEnable,
   output logic             txFaultOut,
   output logic             txFaultOe,
   // receiver
   input  wire logic        rxPowerLow,
   output logic             receiveSignalLost,
   // calibrated live values
   input  wire logic [15:0] tempVal,
   input  wire logic [15:0] supplyVal,
   input  wire logic [15:0] biasVal,
   input  wire logic [15:0] txPowerVal,
   input  wire logic [15:0] rxPowerVal,
   // two-wire serial port
   input  wire logic        scl,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe
);
   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } omc_i2c_state_type;

   omc_i2c_state_type state;
   logic       sclPrev;
   logic       sdaPrev;
   logic [7:0] shiftReg;
   logic [3:0] bitCnt;
   logic [7:0] ptr;
   logic       page;
   logic       readMode;
   logic       hostAck;
   logic       softDisable;
   logic [7:0] idMem   [omc_pkg::OMC_MEM_DEPTH];
   logic [7:0] diagMem [omc_pkg::OMC_MEM_DEPTH];

   logic       txOffStat;
   logic       txFaultStat;
   logic [79:0] liveVal;
   logic [79:0] heldVal;

   // bus events
   logic       sclRise;
   logic       sclFall;
   logic       startCond;
   logic       stopCond;
   logic       byteFull;
   logic       addrMatch;
   logic       busy;
   assign sclRise   = scl & ~sclPrev;
   assign sclFall   = ~scl & sclPrev;
   assign startCond = scl & sclPrev & sdaPrev & ~sdaIn;
   assign stopCond  = scl & sclPrev & ~sdaPrev & sdaIn;
   assign byteFull  = (bitCnt == omc_pkg::OMC_BYTE_BITS);
   assign addrMatch = (shiftReg[7:1] == omc_pkg::OMC_ID_DEV) ||    // [R15]
                      (shiftReg[7:1] == omc_pkg::OMC_DIAG_DEV);    // [R16]
   assign busy      = (state != ST_IDLE);

   // diagnostic value decode, big-endian words from the base
   logic       inDiag;
   logic       isCtrl;
   logic [7:0] diagOff;
   logic [6:0] diagBit;
   logic [15:0] diagWord;
   logic [7:0] diagByte;
   logic [7:0] ctrlByte;
   assign inDiag   = (ptr >= omc_pkg::OMC_DIAG_BASE) && (ptr < omc_pkg::OMC_DIAG_END);
   assign isCtrl   = (ptr == omc_pkg::OMC_CTRL_OFFSET);
   assign diagOff  = ptr - omc_pkg::OMC_DIAG_BASE;
   assign diagBit  = {diagOff[3:1], 4'h0};
   assign diagWord = heldVal[diagBit +: 16];                      // [R17]
   assign diagByte = diagOff[0] ? diagWord[7:0] : diagWord[15:8];

   // control byte: unlisted bits read as zero
   always_comb begin
      ctrlByte = 8'h00;
      ctrlByte[omc_pkg::OMC_TXOFF_BIT] = txOffStat;                // [R4]
      ctrlByte[omc_pkg::OMC_SOFT_BIT]  = softDisable;
      ctrlByte[omc_pkg::OMC_FAULT_BIT] = txFaultStat;              // [R11]
      ctrlByte[omc_pkg::OMC_LOS_BIT]   = receiveSignalLost;        // [R14]
   end

   // read byte selection per page
   logic [7:0] rdByte;
   assign rdByte = !page ? idMem[ptr] :
                   isCtrl ? ctrlByte :
                   inDiag ? diagByte : diagMem[ptr];

   // a data byte lands at the falling edge after its eighth bit
   logic memWrite;
   assign memWrite = (state == ST_WDATA) && sclFall && byteFull && !startCond && !stopCond;

   // edge history of the serial lines
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= scl;
         sdaPrev <= sdaIn;
      end
   end

   // serial slave: sample on rising clock, drive on falling clock
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= ST_IDLE;
         shiftReg <= 8'h00;
         bitCnt   <= 4'h0;
         ptr      <= 8'h00;
         page     <= 1'b0;
         readMode <= 1'b0;
         hostAck  <= 1'b0;
         sdaOe    <= 1'b0;
      end else if (startCond) begin
         state  <= ST_ADDR;
         bitCnt <= 4'h0;
         sdaOe  <= 1'b0;
      end else if (stopCond) begin
         state <= ST_IDLE;
         sdaOe <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
            end
            ST_ADDR, ST_WORD, ST_WDATA: begin
               if (sclRise) begin
                  shiftReg <= {shiftReg[6:0], sdaIn};
                  bitCnt   <= bitCnt + 4'h1;
               end else if (sclFall && byteFull) begin
                  bitCnt <= 4'h0;
                  if (state == ST_ADDR) begin
                     if (addrMatch) begin                         // [R15] [R16]
                        sdaOe    <= 1'b1;
                        page     <= shiftReg[omc_pkg::OMC_PAGE_BIT];
                        readMode <= shiftReg[omc_pkg::OMC_DIR_BIT];
                        state    <= ST_ADDR_ACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else if (state == ST_WORD) begin
                     ptr   <= shiftReg;
                     sdaOe <= 1'b1;
                     state <= ST_WORD_ACK;
                  end else begin
                     ptr   <= ptr + 8'h01;
                     sdaOe <= 1'b1;
                     state <= ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK, ST_WORD_ACK, ST_WDATA_ACK: begin
               if (sclFall) begin
                  bitCnt <= 4'h0;
                  if (state == ST_ADDR_ACK && readMode) begin
                     shiftReg <= rdByte;
                     sdaOe    <= ~rdByte[7];
                     state    <= ST_RDATA;
                  end else begin
                     sdaOe <= 1'b0;
                     state <= (state == ST_ADDR_ACK) ? ST_WORD : ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               if (sclRise) begin
                  bitCnt <= bitCnt + 4'h1;
               end else if (sclFall) begin
                  if (byteFull) begin
                     sdaOe  <= 1'b0;
                     ptr    <= ptr + 8'h01;
                     bitCnt <= 4'h0;
                     state  <= ST_RDATA_ACK;
                  end else begin
                     shiftReg <= {shiftReg[6:0], 1'b0};
                     sdaOe    <= ~shiftReg[6];
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (sclRise) begin
                  hostAck <= ~sdaIn;
               end else if (sclFall) begin
                  if (hostAck) begin
                     shiftReg <= rdByte;
                     sdaOe    <= ~rdByte[7];
                     state    <= ST_RDATA;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // the line is only ever pulled low
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sdaOut <= 1'b0;
      end else begin
         sdaOut <= 1'b0;
      end
   end

   // software disable bit in the control byte
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         softDisable <= omc_pkg::OMC_SOFT_RESET;                  // [R18]
      end else if (memWrite && page && isCtrl) begin
         softDisable <= shiftReg[omc_pkg::OMC_SOFT_BIT];          // [R3]
      end
   end

   // page storage; live values and control byte are not stored here
   always_ff @(posedge sys_clk) begin
      if (memWrite && !page) begin
         idMem[ptr] <= shiftReg;
      end
      if (memWrite && page && !isCtrl && !inDiag) begin
         diagMem[ptr] <= shiftReg;
      end
   end

   assign liveVal = {rxPowerVal, txPowerVal, biasVal, supplyVal, tempVal};

   // transmitter disable and fault logic
   omc_tx_guard u_tx_guard (
      .sys_clk       (sys_clk),
      .arst_n        (arst_n),
      .txOffPin      (txOffPin),
      .txOffFloat    (txOffFloat),
      .softDisable   (softDisable),
      .laserFaultDet (laserFaultDet),
      .lowSupply     (lowSupply),
      .laserEnable   (laserEnable),
      .txFaultOe     (txFaultOe),
      .txFaultOut    (txFaultOut),
      .txOffStat     (txOffStat),
      .txFaultStat   (txFaultStat)
   );

   // receiver status and value snapshot
   omc_rx_diag u_rx_diag (
      .sys_clk           (sys_clk),
      .arst_n            (arst_n),
      .rxPowerLow        (rxPowerLow),
      .liveVal           (liveVal),
      .freeze            (busy),
      .receiveSignalLost (receiveSignalLost),
      .heldVal           (heldVal)
   );

   addr_ack_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
      (state == ST_ADDR && sclFall && byteFull && addrMatch && !startCond && !stopCond)
      |=> (sdaOe && state == ST_ADDR_ACK)) else $error("address not acked");
   // a stored one turns the laser off the cycle after it lands
   soft_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R3]
      (memWrite && page && isCtrl && shiftReg[omc_pkg::OMC_SOFT_BIT])
      |=> softDisable ##1 !laserEnable) else $error("soft disable not stored");
   soft_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R3]
      (memWrite && page && isCtrl && !shiftReg[omc_pkg::OMC_SOFT_BIT])
      |=> !softDisable) else $error("soft disable not cleared");

   // status bits seen by a read follow the live pin state
   ctrl_bits_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R4] [R11] [R14]
      (page && isCtrl) |-> (rdByte[omc_pkg::OMC_TXOFF_BIT] == txOffStat
      && rdByte[omc_pkg::OMC_FAULT_BIT] == txFaultStat
      && rdByte[omc_pkg::OMC_LOS_BIT] == receiveSignalLost))
      else $error("control byte bits wrong");

   // framing: start rearms the address, stop always lets go of the wire
   start_addr_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
      startCond |=> (state == ST_ADDR && bitCnt == 4'h0 && !sdaOe))
      else $error("start not taken");
   stop_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
      stopCond |=> (state == ST_IDLE && !sdaOe)) else $error("stop not taken");
   foreign_nack_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R16]
      (state == ST_ADDR && sclFall && byteFull && !addrMatch && !startCond && !stopCond)
      |=> (!sdaOe && state == ST_IDLE)) else $error("foreign address acked");
   ack_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
      ((state == ST_WORD_ACK || state == ST_WDATA_ACK) && sclFall && !startCond && !stopCond)
      |=> !sdaOe) else $error("ack held too long");

   // reads: first bit driven at the ack fall, pointer steps once per byte
   read_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
      (state == ST_ADDR_ACK && readMode && sclFall && !startCond && !stopCond)
      |=> (sdaOe == !$past(rdByte[7]))) else $error("read bit not driven");
   ptr_step_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
      (state == ST_RDATA && sclFall && byteFull && !startCond && !stopCond)
      |=> (ptr == $past(ptr) + 8'h01)) else $error("pointer did not step");
   // the snapshot must not move while a transfer runs, or words tear
   snapshot_freeze_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R17]
      busy |=> $stable(heldVal)) else $error("snapshot moved during transfer");
endmodule // omc_control_status

// File: omc_host_model.sv
`timescale 1ns/1ps
module omc_host_model (
   // clock
   input  wire logic sys_clk,
   // device side of the serial data wire
   input  wire logic devSdaOe,
   // wire levels seen by the device
   output logic      scl,
   output logic      sdaLevel
);
   logic hostSdaLow;

   // open-drain data wire with a pull-up, low while either side pulls it
   assign sdaLevel = ~(hostSdaLow | devSdaOe);

   // bus idles high on both lines
   initial begin
      scl = 1'b1;
      hostSdaLow = 1'b0;
   end

   // one clock bit: data set while low, sampled late in the high phase
   task automatic bitCycle(input logic drive, output logic seen);
      @(posedge sys_clk);
      hostSdaLow <= ~drive;
      repeat (3) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (4) @(posedge sys_clk);
      seen = sdaLevel;
      scl <= 1'b0;
   endtask

   // start also serves as repeated start, so it raises the clock itself
   task automatic start();
      @(posedge sys_clk);
      hostSdaLow <= 1'b0;
      repeat (3) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (4) @(posedge sys_clk);
      hostSdaLow <= 1'b1;
      repeat (4) @(posedge sys_clk);
      scl <= 1'b0;
   endtask

   // stop leaves both lines released and high
   task automatic stop();
      @(posedge sys_clk);
      hostSdaLow <= 1'b1;
      repeat (3) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (4) @(posedge sys_clk);
      hostSdaLow <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   // eight bits most significant first, then the device's acknowledge
   task automatic sendByte(input logic [7:0] value, output logic acked);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(value[i], seen);
      end
      bitCycle(1'b1, seen);
      acked = ~seen;
   endtask

   // host releases the wire for data, then acks or ends with a nack
   task automatic readByte(input logic lastByte, output logic [7:0] value);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(1'b1, seen);
         value[i] = seen;
      end
      bitCycle(lastByte, seen);
   endtask
endmodule // omc_host_model

// File: omc_control_status_bench.sv
`timescale 1ns/1ps
module omc_control_status_bench;
   // row fields: off, float, fault, low, weak rx | enable, fault level, lost
   typedef struct packed {
      logic [4:0] stim;
      logic       en;
      logic       lvl;
      logic       lost;
   } omc_row_type;
   localparam int LIMIT = 40000;
   omc_row_type rows [6] = '{8'h04, 8'h80, 8'h40, 8'h12, 8'h0d, 8'h89};
   logic [15:0] diagVal [5] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081, 16'h92a3};
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        txOffPin = 1'b0;
   logic        txOffFloat = 1'b0;
   logic        laserFaultDet = 1'b0;
   logic        lowSupply = 1'b0;
   logic        rxPowerLow = 1'b0;
   logic        laserEnable, txFaultOut, txFaultOe, receiveSignalLost;
   logic        scl, sdaLevel, sdaOut, sdaOe, faultLevel, ack;
   logic [7:0]  rdA, rdB;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;

   // fault pin is open collector, host pull-up shows high when released
   assign faultLevel = txFaultOe ? txFaultOut : 1'b1;

   always #25 sys_clk = ~sys_clk;

   omc_control_status dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .txOffPin(txOffPin),
      .txOffFloat(txOffFloat), .laserFaultDet(laserFaultDet), .lowSupply(lowSupply),
      .laserEnable(laserEnable), .txFaultOut(txFaultOut), .txFaultOe(txFaultOe),
      .rxPowerLow(rxPowerLow), .receiveSignalLost(receiveSignalLost),
      .tempVal(diagVal[0]), .supplyVal(diagVal[1]), .biasVal(diagVal[2]),
      .txPowerVal(diagVal[3]), .rxPowerVal(diagVal[4]), .scl(scl), .sdaIn(sdaLevel),
      .sdaOut(sdaOut), .sdaOe(sdaOe));

   omc_host_model host_u (.sys_clk(sys_clk), .devSdaOe(sdaOe), .scl(scl), .sdaLevel(sdaLevel));

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a hang counts as a mismatch and still reaches the report
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail_count++;
         summarize();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // sample just after the edge so registered outputs have landed
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic regWrite(input logic [6:0] dev, input logic [7:0] word, input logic [7:0] data);
      host_u.start();
      host_u.sendByte({dev, 1'b0}, ack);
      check("address ack", ack, 16'h1);
      host_u.sendByte(word, ack);
      host_u.sendByte(data, ack);
      host_u.stop();
   endtask

   // two bytes read back to back, so the pointer step is exercised too
   task automatic regRead(input logic [6:0] dev, input logic [7:0] word);
      host_u.start();
      host_u.sendByte({dev, 1'b0}, ack);
      host_u.sendByte(word, ack);
      host_u.start();
      host_u.sendByte({dev, 1'b1}, ack);
      host_u.readByte(1'b0, rdA);
      host_u.readByte(1'b1, rdB);
      host_u.stop();
   endtask

   // one-cycle pulse on the fault detector or on the transmit-off pin
   task automatic pulse(input logic onFault);
      @(posedge sys_clk);
      if (onFault) begin
         laserFaultDet <= 1'b1;
      end else begin
         txOffPin <= 1'b1;
      end
      @(posedge sys_clk);
      if (onFault) begin
         laserFaultDet <= 1'b0;
      end else begin
         txOffPin <= 1'b0;
      end
   endtask

   initial begin
      settle(4);
      check("enable in reset", laserEnable, 16'h0);
      check("lost in reset", receiveSignalLost, 16'h1);
      check("sda data", sdaOut, 16'h0);
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      settle(3);
      regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET);
      check("control after reset", rdA, 16'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge sys_clk);
         {txOffPin, txOffFloat, laserFaultDet, lowSupply, rxPowerLow} <= rows[i].stim;
         settle(2);
         check("laserEnable", laserEnable, rows[i].en);
         check("fault pin", faultLevel, rows[i].lvl);
         check("lost", receiveSignalLost, rows[i].lost);
      end
      regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET);
      check("control off and lost", rdA, 16'h82);
      @(posedge sys_clk);
      {txOffPin, rxPowerLow} <= 2'h0;
      $display("test pin table done");
      regWrite(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET, 8'hff);
      settle(2);
      check("soft off", laserEnable, 16'h0);
      regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET);
      check("control soft bit", rdA, 16'h40);
      regWrite(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET, 8'h00);
      settle(2);
      check("soft on", laserEnable, 16'h1);
      $display("test soft disable done");
      pulse(1'b1);
      settle(4);
      check("latched fault", faultLevel, 16'h1);
      check("fault off", laserEnable, 16'h0);
      regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET);
      check("control fault", rdA, 16'h04);
      // a toggle while the fault persists must not clear the latch
      @(posedge sys_clk);
      laserFaultDet <= 1'b1;
      pulse(1'b0);
      @(posedge sys_clk);
      laserFaultDet <= 1'b0;
      settle(3);
      check("fault kept", faultLevel, 16'h1);
      pulse(1'b0);
      settle(2);
      check("fault cleared", faultLevel, 16'h0);
      check("laser back", laserEnable, 16'h1);
      $display("test fault latch done");
      for (int i = 0; i < 5; i++) begin
         regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_DIAG_BASE + 8'(2 * i));
         check("live value", {rdA, rdB}, diagVal[i]);
      end
      regWrite(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_DIAG_BASE, 8'h00);
      regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_DIAG_BASE);
      check("live value kept", rdA, diagVal[0][15:8]);
      $display("test diagnostics done");
      regWrite(omc_pkg::OMC_ID_DEV, 8'h10, 8'h5a);
      regWrite(omc_pkg::OMC_DIAG_DEV, 8'h10, 8'ha5);
      regRead(omc_pkg::OMC_ID_DEV, 8'h10);
      check("id page", rdA, 16'h5a);
      regRead(omc_pkg::OMC_DIAG_DEV, 8'h10);
      check("diag page", rdA, 16'ha5);
      host_u.start();
      host_u.sendByte({7'h52, 1'b0}, ack);
      check("foreign address", ack, 16'h0);
      host_u.stop();
      $display("test pages done");
      // a power cycle in mid-run drops the latch and the soft bit
      regWrite(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET, 8'h40);
      pulse(1'b1);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      settle(3);
      check("fault after power", faultLevel, 16'h0);
      regRead(omc_pkg::OMC_DIAG_DEV, omc_pkg::OMC_CTRL_OFFSET);
      check("control after power", rdA, 16'h00);
      $display("test second reset done");
      summarize();
   end
endmodule // omc_control_status_bench
